// file: logic/tsb_pkg.sv
// shared constants and carrier types for the touch sample buffer and scan timer
package tsb_pkg;
  // register positions on the converter page
  localparam logic [7:0] OFS_RSV_A     = 8'h0B;
  localparam logic [7:0] OFS_RSV_B     = 8'h0C;
  localparam logic [7:0] OFS_BUF_CTRL  = 8'h0D;
  localparam logic [7:0] OFS_RSV_C     = 8'h0E;
  localparam logic [7:0] OFS_SCAN_TMR  = 8'h0F;
  // reset values
  localparam logic [7:0] RST_RSV_A     = 8'h00;
  localparam logic [7:0] RST_RSV_B     = 8'h00;
  localparam logic [7:0] RST_BUF_CTRL  = 8'h00;
  localparam logic [7:0] RST_RSV_C     = 8'h0F;
  localparam logic [7:0] RST_SCAN_TMR  = 8'h40;
  // buffer control fields
  localparam int BC_EN     = 7;
  localparam int BC_SHOT   = 6;
  localparam int BC_LVL_HI = 5;
  localparam int BC_LVL_LO = 3;
  localparam int BC_FULL   = 1;
  localparam int BC_EMPTY  = 0;
  localparam logic [7:0] BC_WR_MASK = 8'hFC;
  // scan timer fields
  localparam int ST_IV_EN  = 7;
  localparam int ST_IV_HI  = 6;
  localparam int ST_IV_LO  = 4;
  localparam int ST_LG_EN  = 3;
  localparam int ST_LG_HI  = 2;
  localparam int ST_LG_LO  = 0;
  // buffer geometry
  localparam int DEPTH     = 64;
  localparam int PTR_W     = 6;
  localparam int CNT_W     = 7;
  localparam int DATA_W    = 12;
  localparam int LVL_STEP  = 8;
  localparam logic [CNT_W-1:0] CNT_FULL = 7'h40;
  // timer: ticks come from the 1 MHz delay clock
  localparam int TICK_PER_US      = 1;
  localparam int IV_STEP_US       = 970;        // 0.97 ms per interval step
  localparam int LG_STEP_CMIN     = 112;        // 1.12 min per long step, hundredths
  localparam int US_PER_CMIN      = 600000;
  localparam int IV_STEP_TICKS    = IV_STEP_US * TICK_PER_US;
  localparam int LG_STEP_TICKS    = LG_STEP_CMIN * US_PER_CMIN * TICK_PER_US;
  localparam logic [2:0] IV_CODE_LONGEST = 3'h0;
  localparam logic [3:0] IV_LONGEST_STEPS = 4'h8;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } sample_s;
endpackage

// file: logic/tsb_mem.sv
// 64-entry result store with registered read data
`timescale 1ns/100ps
module tsb_mem (
  input  wire logic                      clk,    // system clock
  input  wire logic                      ce,     // clock enable
  input  wire logic                      we,     // write strobe
  input  wire logic [tsb_pkg::PTR_W-1:0]  waddr,  // write index
  input  wire logic [tsb_pkg::DATA_W-1:0] wdata,  // write word
  input  wire logic                      re,     // read strobe
  input  wire logic [tsb_pkg::PTR_W-1:0]  raddr,  // read index
  output logic      [tsb_pkg::DATA_W-1:0] rdata   // registered read word
);
  import tsb_pkg::*;
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end
endmodule // tsb_mem

// file: logic/tsb_top.sv
// result buffer control/status and scan interval timers of the touch converter
`timescale 1ns/100ps
module tsb_top #(
  parameter int IV_TICKS = tsb_pkg::IV_STEP_TICKS,  // ticks per interval step
  parameter int LG_TICKS = tsb_pkg::LG_STEP_TICKS   // ticks per long-delay step
) (
  input  wire logic                      clk,          // 40 MHz system clock
  input  wire logic                      sys_rst,      // sync reset, active high
  input  wire logic                      ce,           // clock enable, freezes state
  input  wire tsb_pkg::reg_req_s         reg_req,      // register access request
  output logic      [7:0]                reg_rdata,    // register read data
  input  wire tsb_pkg::sample_s          conv_in,      // converted result offered
  output logic                           conv_ready,   // buffer accepts a result
  output logic                           conv_run,     // converter may keep running
  output logic                           trig_hit,     // trigger level reached
  input  wire logic                      res_rd,       // host pops one result
  output logic      [tsb_pkg::DATA_W-1:0] res_data,    // popped result
  output logic                           res_valid,    // res_data valid pulse
  input  wire logic                      set_done,     // data set finished pulse
  input  wire logic                      timer_tick,   // 1 MHz delay clock enable
  output logic                           set_start,    // start next data set pulse
  input  wire logic [7:0]                chan_new_in,  // per-channel new-data flags
  output logic      [7:0]                chan_new_out  // flags as software sees them
);
  import tsb_pkg::*;

  typedef struct packed {
    logic [7:0]          ctrl;
    logic [7:0]          scan;
    logic [7:0]          rsv_a;
    logic [7:0]          rsv_b;
    logic [7:0]          rsv_c;
    logic [PTR_W-1:0]    buffer_read_pointer;
    logic [PTR_W-1:0]    buffer_write_pointer;
    logic [CNT_W-1:0]    buffer_trigger_pointer;
    logic [CNT_W-1:0]    count;
    logic                shot_done;
    logic [1:0]          sk_n;
    logic [DATA_W-1:0]   sk0;
    logic [DATA_W-1:0]   sk1;
    logic [7:0]          rdata;
    logic                conv_ready;
    logic                conv_run;
    logic                trig_hit;
    logic                res_valid;
    logic                tm_busy;
    logic [31:0]         tm_cnt;
    logic                set_start;
    logic [7:0]          chan_new;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  logic                en;
  logic                shot;
  logic                push;
  logic                pop_sk;
  logic                host_pop;
  logic [DATA_W-1:0]   sk_head;
  logic [DATA_W-1:0]   pushed;
  logic [2:0]          lvl;
  logic [3:0]          iv_steps;
  logic [3:0]          lg_steps;

  assign en       = st_ff.ctrl[BC_EN];
  assign shot     = st_ff.ctrl[BC_SHOT];
  assign lvl      = st_ff.ctrl[BC_LVL_HI:BC_LVL_LO];
  assign sk_head  = st_ff.sk0;
  assign pushed   = conv_in.data;
  // interval code 000 is the longest setting, one step past 111
  assign iv_steps = (st_ff.scan[ST_IV_HI:ST_IV_LO] == IV_CODE_LONGEST) ?
                    IV_LONGEST_STEPS : {1'b0, st_ff.scan[ST_IV_HI:ST_IV_LO]};
  assign lg_steps = {st_ff.scan[ST_LG_HI:ST_LG_LO], 1'b1};

  // drain the skid entry into the store unless full or a single shot has completed
  assign pop_sk   = en && (st_ff.sk_n != 2'd0) && (st_ff.count != CNT_FULL) &&
                    !(shot && st_ff.shot_done);
  assign host_pop = en && res_rd && (st_ff.count != '0);
  assign push     = conv_in.valid && st_ff.conv_ready;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.set_start = 1'b0;
    nxt_st.res_valid = host_pop;

    // register writes; reserved positions simply store what software writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        OFS_RSV_A:    nxt_st.rsv_a = reg_req.wdata;
        OFS_RSV_B:    nxt_st.rsv_b = reg_req.wdata;
        OFS_BUF_CTRL: nxt_st.ctrl  = reg_req.wdata & BC_WR_MASK;
        OFS_RSV_C:    nxt_st.rsv_c = reg_req.wdata;
        OFS_SCAN_TMR: nxt_st.scan  = reg_req.wdata;
        default:      nxt_st.rsv_a = st_ff.rsv_a;
      endcase
    end

    // skid pair: pop head, then append the offered word
    if (pop_sk) begin
      nxt_st.sk0  = st_ff.sk1;
      nxt_st.sk_n = st_ff.sk_n - 2'd1;
    end
    if (push) begin
      if (nxt_st.sk_n == 2'd0) begin
        nxt_st.sk0 = pushed;
      end else begin
        nxt_st.sk1 = pushed;
      end
      nxt_st.sk_n = nxt_st.sk_n + 2'd1;
    end

    // circular pointers wrap naturally at 64
    if (pop_sk) begin
      nxt_st.buffer_write_pointer = st_ff.buffer_write_pointer + 6'd1;
    end
    if (host_pop) begin
      nxt_st.buffer_read_pointer = st_ff.buffer_read_pointer + 6'd1;
    end
    nxt_st.count = st_ff.count + {6'd0, pop_sk} - {6'd0, host_pop};
    nxt_st.buffer_trigger_pointer = CNT_W'((32'(lvl) + 1) * LVL_STEP);

    if (pop_sk && (nxt_st.count >= st_ff.buffer_trigger_pointer)) begin
      nxt_st.shot_done = 1'b1;
    end else if (nxt_st.count == '0) begin
      nxt_st.shot_done = 1'b0;
    end

    // disabling drops everything held and parks the read and write pointers at zero
    if (!nxt_st.ctrl[BC_EN]) begin
      nxt_st.buffer_read_pointer  = '0;
      nxt_st.buffer_write_pointer = '0;
      nxt_st.count                = '0;
      nxt_st.sk_n                 = 2'd0;
      nxt_st.shot_done            = 1'b0;
    end
    // while disabled results are not kept, so the converter is never stalled
    nxt_st.conv_ready = !nxt_st.ctrl[BC_EN] || (nxt_st.sk_n != 2'd2);
    nxt_st.conv_run   = nxt_st.ctrl[BC_EN] &&
                        !(nxt_st.ctrl[BC_SHOT] && nxt_st.shot_done);
    nxt_st.trig_hit   = nxt_st.ctrl[BC_EN] &&
                        (nxt_st.count >= nxt_st.buffer_trigger_pointer);
    nxt_st.chan_new   = nxt_st.ctrl[BC_EN] ? 8'h00 : chan_new_in;

    // delay between data sets; the long delay takes precedence when both are on
    if (set_done) begin
      nxt_st.tm_busy = 1'b1;
      if (st_ff.scan[ST_LG_EN]) begin
        nxt_st.tm_cnt = 32'(lg_steps) * 32'(LG_TICKS);
      end else if (st_ff.scan[ST_IV_EN]) begin
        nxt_st.tm_cnt = 32'(iv_steps) * 32'(IV_TICKS);
      end else begin
        nxt_st.tm_cnt = 32'd0;
      end
    end else if (st_ff.tm_busy) begin
      if (st_ff.tm_cnt == 32'd0) begin
        nxt_st.tm_busy   = 1'b0;
        nxt_st.set_start = 1'b1;
      end else if (timer_tick) begin
        nxt_st.tm_cnt = st_ff.tm_cnt - 32'd1;
      end
    end

    if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_RSV_A:    nxt_st.rdata = st_ff.rsv_a;
        OFS_RSV_B:    nxt_st.rdata = st_ff.rsv_b;
        OFS_BUF_CTRL: nxt_st.rdata = {st_ff.ctrl[7:2], (st_ff.count == CNT_FULL),
                                      (st_ff.count == '0)};
        OFS_RSV_C:    nxt_st.rdata = st_ff.rsv_c;
        OFS_SCAN_TMR: nxt_st.rdata = st_ff.scan;
        default:      nxt_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff            <= '0;
      st_ff.ctrl       <= RST_BUF_CTRL;
      st_ff.scan       <= RST_SCAN_TMR;
      st_ff.rsv_a      <= RST_RSV_A;
      st_ff.rsv_b      <= RST_RSV_B;
      st_ff.rsv_c      <= RST_RSV_C;
      st_ff.buffer_trigger_pointer <= CNT_W'(LVL_STEP);
      st_ff.conv_ready <= 1'b1;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  tsb_mem tsb_mem_inst (
    .clk   (clk),
    .ce    (ce),
    .we    (pop_sk),
    .waddr (st_ff.buffer_write_pointer),
    .wdata (sk_head),
    .re    (host_pop),
    .raddr (st_ff.buffer_read_pointer),
    .rdata (res_data)
  );

  assign reg_rdata    = st_ff.rdata;
  assign conv_ready   = st_ff.conv_ready;
  assign conv_run     = st_ff.conv_run;
  assign trig_hit     = st_ff.trig_hit;
  assign res_valid    = st_ff.res_valid;
  assign set_start    = st_ff.set_start;
  assign chan_new_out = st_ff.chan_new;

  // ---------------- assertions ----------------
  sequence s_ctrl_rd;
    ce && reg_req.rd && (reg_req.addr == OFS_BUF_CTRL);
  endsequence

  sequence s_disable_wr;
    ce && reg_req.wr && (reg_req.addr == OFS_BUF_CTRL) && !reg_req.wdata[BC_EN];
  endsequence

  AST_DISABLE_CLEARS: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_disable_wr |=> (st_ff.count == '0) && (st_ff.buffer_read_pointer == '0) &&
                     (st_ff.buffer_write_pointer == '0) && !conv_run)
    else $error("disable did not clear buffer pointers");

  AST_SHOT_STOPS: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (en && shot && st_ff.shot_done) |-> !conv_run && !pop_sk)
    else $error("single shot kept filling after trigger");

  AST_CONT_RUNS: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (en && !shot && $past(en) && $past(ce)) |-> conv_run)
    else $error("continuous mode stopped the converter");

  AST_TRIG_LEVEL: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    $past(ce) |-> (st_ff.buffer_trigger_pointer == CNT_W'((32'($past(lvl)) + 1) * LVL_STEP)))
    else $error("trigger threshold does not match level code");

  AST_FULL_FLAG: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_ctrl_rd |=> (reg_rdata[BC_FULL] == ($past(st_ff.count) == CNT_FULL)))
    else $error("full flag wrong");

  AST_EMPTY_FLAG: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_ctrl_rd |=> (reg_rdata[BC_EMPTY] == ($past(st_ff.count) == '0)))
    else $error("empty flag wrong");

  AST_NO_OVERFILL: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (st_ff.count == CNT_FULL) |-> !pop_sk)
    else $error("write into a full buffer");

  AST_NO_DELAY: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (set_done && !st_ff.scan[ST_IV_EN] && !st_ff.scan[ST_LG_EN]) ##1 ce |=> set_start)
    else $error("next data set not started without delay");

  AST_IV_WAIT: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (set_done && st_ff.scan[ST_IV_EN] && !st_ff.scan[ST_LG_EN]) |=> !set_start [*2])
    else $error("interval delay skipped");

  AST_MASK_NEW: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (nxt_st.ctrl[BC_EN]) |=> (chan_new_out == 8'h00))
    else $error("channel flags visible in buffer mode");

  AST_WRAP: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    (pop_sk && nxt_st.ctrl[BC_EN]) |=>
      (st_ff.buffer_write_pointer == $past(st_ff.buffer_write_pointer) + 6'd1))
    else $error("write pointer did not advance");
endmodule // tsb_top

// file: sim/tsb_host_model.sv
// host model: register access and result pops on the block's own port
`timescale 1ns/100ps
module tsb_host_model (
  input  wire logic                       clk,        // system clock
  output tsb_pkg::reg_req_s               reg_req,    // register access request
  input  wire logic [7:0]                 reg_rdata,  // register read data
  output logic                            res_rd,     // pop one result
  input  wire logic [tsb_pkg::DATA_W-1:0] res_data,   // popped result
  input  wire logic                       res_valid   // popped result valid
);
  import tsb_pkg::*;
  initial begin
    reg_req = '0;
    res_rd  = 1'b0;
  end
  // reserved places only ever get their reset pattern back
  function automatic logic [7:0] legal_value(input logic [7:0] a, input logic [7:0] d);
    case (a)
      OFS_RSV_A: return RST_RSV_A;
      OFS_RSV_B: return RST_RSV_B;
      OFS_RSV_C: return RST_RSV_C;
      default:   return d;
    endcase
  endfunction
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: legal_value(a, d)};
    @(negedge clk);
    reg_req <= '0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    reg_req <= '0;
    d = reg_rdata;
  endtask
  // gap lets the host be slow between pops
  task automatic pop(input int gap, output logic [DATA_W-1:0] d, output logic v);
    repeat (gap + 1) @(negedge clk);
    res_rd <= 1'b1;
    @(negedge clk);
    res_rd <= 1'b0;
    d = res_data;
    v = res_valid;
  endtask
endmodule // tsb_host_model

// file: sim/touch_sample_buffer_scan_timer_tb.sv
// self-checking bench for the result buffer control and scan timers
`timescale 1ns/100ps
module touch_sample_buffer_scan_timer_tb;
  import tsb_pkg::*;
  logic              clk;
  logic              sys_rst;
  logic              ce;
  reg_req_s          reg_req;
  logic [7:0]        reg_rdata;
  sample_s           conv_in;
  logic              conv_ready;
  logic              conv_run;
  logic              trig_hit;
  logic              res_rd;
  logic [DATA_W-1:0] res_data;
  logic              res_valid;
  logic              set_done;
  logic              timer_tick;
  logic              set_start;
  logic [7:0]        chan_new_in;
  logic [7:0]        chan_new_out;
  logic [7:0]        rd;
  logic [DATA_W-1:0] pd;
  logic              pv;
  int                num_errors = 0;
  int                checked = 0;
  int                cycles = 0;

  tsb_top #(.IV_TICKS(4), .LG_TICKS(8)) tsb_top_inst (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .conv_in(conv_in), .conv_ready(conv_ready), .conv_run(conv_run), .trig_hit(trig_hit),
    .res_rd(res_rd), .res_data(res_data), .res_valid(res_valid), .set_done(set_done),
    .timer_tick(timer_tick), .set_start(set_start), .chan_new_in(chan_new_in),
    .chan_new_out(chan_new_out));
  tsb_host_model tsb_host_model_inst (
    .clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .res_rd(res_rd),
    .res_data(res_data), .res_valid(res_valid));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic summarize;
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    tsb_host_model_inst.reg_read(a, rd);
    check("register read", {8'h00, exp}, {8'h00, rd});
  endtask
  // hold the word until an edge where the buffer is ready
  task automatic push(input logic [11:0] d);
    int n;
    n = 0;
    @(negedge clk);
    conv_in <= '{valid: 1'b1, data: d};
    while (conv_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    conv_in.valid <= 1'b0;
  endtask
  task automatic popchk(input int gap, input logic [11:0] exp);
    tsb_host_model_inst.pop(gap, pd, pv);
    check("popped result", {4'h1, exp}, {3'h0, pv, pd});
  endtask
  task automatic tcase(input logic [7:0] cfg, input int lo, input int hi);
    int n;
    tsb_host_model_inst.reg_write(OFS_SCAN_TMR, cfg);
    rchk(OFS_SCAN_TMR, cfg);
    @(negedge clk);
    set_done <= 1'b1;
    @(negedge clk);
    set_done <= 1'b0;
    n = 1;
    while (set_start !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    checked++;
    if (n < lo || n > hi) begin
      num_errors++;
      $display("FAIL set_start delay expected %0d..%0d seen %0d", lo, hi, n);
    end
    @(negedge clk);
    check("set_start width", 16'h0000, {15'h0, set_start});
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    conv_in = '0;
    set_done = 1'b0;
    timer_tick = 1'b1;
    chan_new_in = 8'hA5;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    rchk(OFS_BUF_CTRL, 8'h01);
    rchk(OFS_SCAN_TMR, 8'h40);
    rchk(OFS_RSV_C, 8'h0F);
    rchk(8'h10, 8'h00);
    tsb_host_model_inst.reg_write(OFS_RSV_C, 8'h55);
    rchk(OFS_RSV_C, 8'h0F);
    check("chan_new_out", 16'h00A5, {8'h00, chan_new_out});
    tsb_host_model_inst.pop(0, pd, pv);
    check("pop while disabled", 16'h0000, {15'h0, pv});
    // read-only flag bits ignore the write
    tsb_host_model_inst.reg_write(OFS_BUF_CTRL, 8'h83);
    rchk(OFS_BUF_CTRL, 8'h81);
    chan_new_in = 8'h5A;
    repeat (2) @(negedge clk);
    check("chan_new_out", 16'h0000, {8'h00, chan_new_out});
    for (int i = 0; i < 64; i++) push(12'h100 + 12'(i));
    repeat (3) @(negedge clk);
    rchk(OFS_BUF_CTRL, 8'h82);
    check("trig_hit", 16'h0001, {15'h0, trig_hit});
    for (int i = 0; i < 64; i++) popchk(i % 3, 12'h100 + 12'(i));
    rchk(OFS_BUF_CTRL, 8'h81);
    tsb_host_model_inst.pop(0, pd, pv);
    check("pop while empty", 16'h0000, {15'h0, pv});
    for (int i = 0; i < 5; i++) push(12'hA00 + 12'(i));
    for (int i = 0; i < 5; i++) popchk(0, 12'hA00 + 12'(i));
    for (int c = 0; c < 8; c++) begin
      tsb_host_model_inst.reg_write(OFS_BUF_CTRL, 8'h00);
      rchk(OFS_BUF_CTRL, 8'h01);
      tsb_host_model_inst.reg_write(OFS_BUF_CTRL, {2'b10, 3'(c), 3'b000});
      for (int i = 0; i < (c + 1) * 8 - 1; i++) push(12'(i));
      repeat (3) @(negedge clk);
      check("trig_hit below", 16'h0000, {15'h0, trig_hit});
      push(12'hFFF);
      repeat (3) @(negedge clk);
      check("trig_hit at level", 16'h0001, {15'h0, trig_hit});
    end
    rchk(OFS_BUF_CTRL, 8'hBA);
    tsb_host_model_inst.reg_write(OFS_BUF_CTRL, 8'h00);
    check("trig_hit disabled", 16'h0000, {15'h0, trig_hit});
    tsb_host_model_inst.reg_write(OFS_BUF_CTRL, 8'hC0);
    for (int i = 0; i < 8; i++) push(12'h300 + 12'(i));
    repeat (3) @(negedge clk);
    check("conv_run single shot", 16'h0000, {15'h0, conv_run});
    rchk(OFS_BUF_CTRL, 8'hC0);
    // a finished shot refuses further words: the skid fills and ready drops
    push(12'h3F0);
    push(12'h3F1);
    check("conv_ready stalled", 16'h0000, {15'h0, conv_ready});
    for (int i = 0; i < 8; i++) popchk(0, 12'h300 + 12'(i));
    repeat (2) @(negedge clk);
    check("conv_run after drain", 16'h0001, {15'h0, conv_run});
    check("conv_ready after drain", 16'h0001, {15'h0, conv_ready});
    tsb_host_model_inst.reg_write(OFS_BUF_CTRL, 8'h00);
    tsb_host_model_inst.reg_write(OFS_BUF_CTRL, 8'h80);
    for (int i = 0; i < 8; i++) push(12'(i));
    repeat (3) @(negedge clk);
    check("conv_run continuous", 16'h0001, {15'h0, conv_run});
    tcase(8'h00, 1, 3);
    tcase(8'h90, 4, 8);
    tcase(8'h80, 32, 36);
    tcase(8'h08, 8, 12);
    tcase(8'h0B, 56, 60);
    tcase(8'h98, 8, 12);
    // a frozen block ignores register writes
    ce = 1'b0;
    tsb_host_model_inst.reg_write(OFS_SCAN_TMR, 8'h11);
    ce = 1'b1;
    rchk(OFS_SCAN_TMR, 8'h98);
    // reset in mid-run drops buffered results and restores every register
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    rchk(OFS_BUF_CTRL, 8'h01);
    rchk(OFS_SCAN_TMR, 8'h40);
    check("trig_hit after reset", 16'h0000, {15'h0, trig_hit});
    check("chan_new_out after reset", 16'h005A, {8'h00, chan_new_out});
    tsb_host_model_inst.pop(0, pd, pv);
    check("pop after reset", 16'h0000, {15'h0, pv});
    summarize();
  end
endmodule // touch_sample_buffer_scan_timer_tb
